// *** verilog/ppw_port_ctl.sv ***
// Purpose: port A pin control, wake sources, edge interrupts, port C enables
// Assumes: cpu register-file bus on the system clock; pins are asynchronous
// Notes:   peripheral direction and outputs come in per alternate function
//
// What this block does
// - alternate function pins take peripheral direction
// - two set subregisters pick the alternate function
// - crystal enable overrides pins zero and one
// - enabled pin transitions in stop start recovery
// - polarity bit picks falling or rising interrupt
// - low four bits hold port C enables
// - wake, polarity and enable registers reset zero
`timescale 1ns/1ps
`include "ppw_consts.svh"

module ppw_port_ctl #(
  parameter int PINS = 8
) (
  input  wire logic                    core_clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic [`PPW_ADDR_W-1:0]  reg_addr_in,
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  input  wire ppw_pkg::ppw_byte_t      reg_wdata_in,
  output logic      [7:0]              reg_rdata_out,
  input  wire logic [PINS-1:0]         pin_in,
  input  wire logic [PINS-1:0]         gpio_out_data_in,
  input  wire logic [PINS-1:0]         periph1_oe_in,
  input  wire logic [PINS-1:0]         periph1_out_in,
  input  wire logic [PINS-1:0]         periph2_oe_in,
  input  wire logic [PINS-1:0]         periph2_out_in,
  input  wire logic [PINS-1:0]         periph3_oe_in,
  input  wire logic [PINS-1:0]         periph3_out_in,
  input  wire logic                    xtal_enable_in,
  input  wire logic                    stop_mode_in,
  input  wire logic                    xtal_osc_out_in,
  output logic      [PINS-1:0]         pin_out,
  output logic      [PINS-1:0]         pin_oe_out,
  output logic      [PINS-1:0]         pin_sync_out,
  output logic                         xtal_in_pin_out,
  output logic      [PINS-1:0]         edge_irq_out,
  output logic      [3:0]              portc_irq_en_low_out,
  output logic                         stop_recovery_out
);

  // elaboration-time refusal of port widths the register map cannot serve
  if (PINS != 8)
  begin
    $error("ppw_port_ctl serves eight-bit ports only");
  end

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  function automatic logic hit(input logic [`PPW_ADDR_W-1:0] a,
                               input logic [`PPW_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  logic [7:0]      sub_addr_q, sub_addr_d;
  logic [7:0]      irq_en_low_q, irq_en_low_d;
  logic [7:0]      edge_pol_q, edge_pol_d;
  logic [7:0]      wake_en_q, wake_en_d;
  logic [7:0]      ddr_q, ddr_d;
  logic [7:0]      alt_en_q, alt_en_d;
  logic [7:0]      afs_first_q, afs_first_d;
  logic [7:0]      afs_second_q, afs_second_d;
  logic [7:0]      rdata_q, rdata_d;
  logic            ctl_wr;

  // next values of the software registers and read data
  always_comb
  begin
    sub_addr_d   = sub_addr_q;
    irq_en_low_d = irq_en_low_q;
    edge_pol_d   = edge_pol_q;
    wake_en_d    = wake_en_q;
    ddr_d        = ddr_q;
    alt_en_d     = alt_en_q;
    afs_first_d  = afs_first_q;
    afs_second_d = afs_second_q;
    rdata_d      = `PPW_RST_BYTE;
    ctl_wr       = reg_wr_in && hit(reg_addr_in, `PPW_OFF_PORT_CTL);
    if (reg_wr_in && hit(reg_addr_in, `PPW_OFF_PORT_ADDR))
      sub_addr_d = reg_wdata_in;
    if (reg_wr_in && hit(reg_addr_in, `PPW_OFF_IRQ_EN_LOW))
      irq_en_low_d = reg_wdata_in & `PPW_IRQ_EN_LOW_MASK;
    if (reg_wr_in && hit(reg_addr_in, `PPW_OFF_EDGE_POL))
      edge_pol_d = reg_wdata_in;
    if (ctl_wr)
    begin
      unique case (sub_addr_q)
        `PPW_SUB_DDR:        ddr_d = reg_wdata_in;
        `PPW_SUB_ALT_FUNC:   alt_en_d = reg_wdata_in;
        `PPW_SUB_WAKE_EN:    wake_en_d = reg_wdata_in;
        `PPW_SUB_AFS_FIRST:  afs_first_d = reg_wdata_in;
        `PPW_SUB_AFS_SECOND: afs_second_d = reg_wdata_in;
        default:             ;
      endcase
    end
    if (reg_rd_in)
    begin
      if (hit(reg_addr_in, `PPW_OFF_PORT_ADDR))
        rdata_d = sub_addr_q;
      else if (hit(reg_addr_in, `PPW_OFF_IRQ_EN_LOW))
        rdata_d = irq_en_low_q;
      else if (hit(reg_addr_in, `PPW_OFF_EDGE_POL))
        rdata_d = edge_pol_q;
      else if (hit(reg_addr_in, `PPW_OFF_PORT_CTL))
      begin
        unique case (sub_addr_q)
          `PPW_SUB_DDR:        rdata_d = ddr_q;
          `PPW_SUB_ALT_FUNC:   rdata_d = alt_en_q;
          `PPW_SUB_WAKE_EN:    rdata_d = wake_en_q;
          `PPW_SUB_AFS_FIRST:  rdata_d = afs_first_q;
          `PPW_SUB_AFS_SECOND: rdata_d = afs_second_q;
          default:             rdata_d = `PPW_RST_BYTE;
        endcase
      end
    end
  end

  // software registers, all clear at reset
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sub_addr_q   <= `PPW_RST_BYTE;
      irq_en_low_q <= `PPW_RST_BYTE;
      edge_pol_q   <= `PPW_RST_BYTE;
      wake_en_q    <= `PPW_RST_BYTE;
      ddr_q        <= `PPW_RST_BYTE;
      alt_en_q     <= `PPW_RST_BYTE;
      afs_first_q  <= `PPW_RST_BYTE;
      afs_second_q <= `PPW_RST_BYTE;
      rdata_q      <= `PPW_RST_BYTE;
    end
    else
    begin
      sub_addr_q   <= sub_addr_d;
      irq_en_low_q <= irq_en_low_d;
      edge_pol_q   <= edge_pol_d;
      wake_en_q    <= wake_en_d;
      ddr_q        <= ddr_d;
      alt_en_q     <= alt_en_d;
      afs_first_q  <= afs_first_d;
      afs_second_q <= afs_second_d;
      rdata_q      <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive: gpio, alternate function, crystal override

  logic [PINS-1:0] oe_d, out_d, oe_q, out_q;

  // per pin mux; ddr bit 1 means input, as on the gpio port
  always_comb
  begin
    for (int i = 0; i < PINS; i++)
    begin
      if (alt_en_q[i])
      begin
        unique case ({afs_second_q[i], afs_first_q[i]})
          2'h1:
          begin
            oe_d[i]  = periph2_oe_in[i];
            out_d[i] = periph2_out_in[i];
          end
          2'h2,
          2'h3:
          begin
            oe_d[i]  = periph3_oe_in[i];
            out_d[i] = periph3_out_in[i];
          end
          default:
          begin
            oe_d[i]  = periph1_oe_in[i];
            out_d[i] = periph1_out_in[i];
          end
        endcase
      end
      else
      begin
        oe_d[i]  = ~ddr_q[i];
        out_d[i] = gpio_out_data_in[i];
      end
    end
    if (xtal_enable_in)
    begin
      oe_d[`PPW_XTAL_IN_BIT]   = 1'b0;
      out_d[`PPW_XTAL_IN_BIT]  = 1'b0;
      oe_d[`PPW_XTAL_OUT_BIT]  = 1'b1;
      out_d[`PPW_XTAL_OUT_BIT] = xtal_osc_out_in;
    end
  end

  // pin drive registers
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      oe_q  <= '0;
      out_q <= '0;
    end
    else
    begin
      oe_q  <= oe_d;
      out_q <= out_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser, edge interrupts and stop recovery

  logic [PINS-1:0]             sync1_q, sync2_q, prev_q, irq_q, irq_d;
  logic                        wake_q, wake_d, xin_q;
  logic [`PPW_HIST_STAGES-1:0] live_q, live_d;

  // edge detect on the second stage only, once the history holds real pin levels;
  // the flops clear at reset, so a pin sitting high would look like a rising edge
  always_comb
  begin
    live_d = {live_q[`PPW_HIST_STAGES-2:0], 1'b1};
    for (int i = 0; i < PINS; i++)
      irq_d[i] = live_q[`PPW_HIST_STAGES-1] &&
                 (edge_pol_q[i] ? (sync2_q[i] & ~prev_q[i])
                                : (~sync2_q[i] & prev_q[i]));
    wake_d = stop_mode_in && live_q[`PPW_HIST_STAGES-1] &&
             |(wake_en_q & (sync2_q ^ prev_q));
  end

  // two-flop sync, history and output pulses
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
      irq_q   <= '0;
      wake_q  <= 1'b0;
      xin_q   <= 1'b0;
      live_q  <= '0;
    end
    else
    begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
      irq_q   <= irq_d;
      wake_q  <= wake_d;
      xin_q   <= sync2_q[`PPW_XTAL_IN_BIT] & xtal_enable_in;
      live_q  <= live_d;
    end
  end

  assign reg_rdata_out        = rdata_q;
  assign pin_out              = out_q;
  assign pin_oe_out           = oe_q;
  assign pin_sync_out         = prev_q;
  assign xtal_in_pin_out      = xin_q;
  assign edge_irq_out         = irq_q;
  assign portc_irq_en_low_out = irq_en_low_q[3:0];
  assign stop_recovery_out    = wake_q;

endmodule

// *** verilog/ppw_consts.svh ***
// Purpose: constants for the port pin wake and edge interrupt block
// Assumes: 12-bit register-file addresses, 8-bit data
// Notes:   definitions only
`ifndef PPW_CONSTS_SVH
`define PPW_CONSTS_SVH

`define PPW_ADDR_W          12
`define PPW_OFF_IRQ_EN_LOW  12'hFC8
`define PPW_OFF_EDGE_POL    12'hFCD
`define PPW_OFF_PORT_ADDR   12'hFD0
`define PPW_OFF_PORT_CTL    12'hFD1
`define PPW_SUB_DDR         8'h01
`define PPW_SUB_ALT_FUNC    8'h02
`define PPW_SUB_WAKE_EN     8'h05
`define PPW_SUB_AFS_FIRST   8'h07
`define PPW_SUB_AFS_SECOND  8'h08
`define PPW_RST_BYTE        8'h00
`define PPW_IRQ_EN_LOW_MASK 8'h0F
`define PPW_XTAL_IN_BIT     0
`define PPW_XTAL_OUT_BIT    1
`define PPW_HIST_STAGES     3

`endif

// *** verilog/ppw_pkg.sv ***
// Purpose: types for the port pin wake and edge interrupt block
// Assumes: nothing
// Notes:   shared type only
package ppw_pkg;
  typedef logic [7:0] ppw_byte_t;
endpackage

// *** verif/ppw_port_ctl_properties.sv ***
// Purpose: checker for the port pin block
// Assumes: bound to ppw_port_ctl
// Notes:   watches top ports only
`timescale 1ns/1ps
`include "ppw_consts.svh"
module ppw_port_ctl_props #(
  parameter int PINS = 8
) (
  input wire logic                   core_clk_in,
  input wire logic                   rst_n_in,
  input wire logic [11:0]            reg_addr_in,
  input wire logic                   reg_wr_in,
  input wire ppw_pkg::ppw_byte_t     reg_wdata_in,
  input wire logic [PINS-1:0]        pin_in,
  input wire logic                   xtal_enable_in,
  input wire logic                   xtal_osc_out_in,
  input wire logic                   stop_mode_in,
  input wire logic [PINS-1:0]        pin_out,
  input wire logic [PINS-1:0]        pin_oe_out,
  input wire logic                   xtal_in_pin_out,
  input wire logic [PINS-1:0]        edge_irq_out,
  input wire logic [3:0]             portc_irq_en_low_out,
  input wire logic                   stop_recovery_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // steady pins and a steady awake spell
  sequence s_quiet; $stable(pin_in) [*6]; endsequence
  sequence s_awake; !stop_mode_in [*5]; endsequence
  chk_xtal_in_hiz: assert property (xtal_enable_in |=> !pin_oe_out[0])
    else $error("crystal input pin driven");
  // the release edge still sees the drive flops in reset, so start after it
  chk_xtal_out_drv: assert property (rst_n_in && xtal_enable_in |=> pin_oe_out[1] &&
    pin_out[1] == $past(xtal_osc_out_in)) else $error("crystal output wrong");
  chk_xtal_in_off: assert property (!xtal_enable_in |=> !xtal_in_pin_out)
    else $error("crystal input live while off");
  chk_edge_single: assert property ((edge_irq_out & $past(edge_irq_out)) == '0)
    else $error("edge request longer than a cycle");
  chk_edge_quiet: assert property (s_quiet |=> edge_irq_out == '0)
    else $error("edge request without a pin edge");
  chk_en_low_wr: assert property (reg_wr_in && reg_addr_in == `PPW_OFF_IRQ_EN_LOW
    |=> portc_irq_en_low_out == $past(reg_wdata_in[3:0])) else $error("enable bits");
  chk_wake_idle: assert property (s_awake |=> !stop_recovery_out)
    else $error("recovery outside stop");
  chk_rst_zero: assert property ($rose(rst_n_in) |-> portc_irq_en_low_out == 4'h0)
    else $error("enable bits not clear after reset");
endmodule
bind ppw_port_ctl ppw_port_ctl_props #(.PINS(PINS)) u_props (.core_clk_in, .rst_n_in,
  .reg_addr_in, .reg_wr_in, .reg_wdata_in, .pin_in, .xtal_enable_in, .xtal_osc_out_in,
  .stop_mode_in, .pin_out, .pin_oe_out, .xtal_in_pin_out, .edge_irq_out,
  .portc_irq_en_low_out, .stop_recovery_out);

// *** verif/ppw_pin_model.sv ***
// Purpose: outside world at the port pins
// Assumes: an outside driver on every pin
// Notes:   device drive wins where enabled
`timescale 1ns/1ps
module ppw_pin_model (
  input  wire logic [7:0] dev_out_in,
  input  wire logic [7:0] dev_oe_in,
  input  wire logic [7:0] ext_val_in,
  output logic      [7:0] pin_level_out
);
  // resolve each wire from both drivers
  assign pin_level_out = (dev_oe_in & dev_out_in) | (~dev_oe_in & ext_val_in);
endmodule

// *** verif/ppw_port_ctl_tb.sv ***
// Purpose: self-checking bench for the port pin block
// Assumes: pin model resolves the wires
// Notes:   fixed seed, corner cases mixed in
`timescale 1ns/1ps
`include "ppw_consts.svh"
module ppw_port_ctl_tb;
  logic               core_clk_in = 1'b0, rst_n_in = 1'b0;
  logic [11:0]        reg_addr_in = 12'h000;
  logic               reg_wr_in = 1'b0, reg_rd_in = 1'b0, xtal_enable_in = 1'b0;
  logic               stop_mode_in = 1'b0, xtal_osc_out_in = 1'b0, xtal_in_pin_out;
  logic               stop_recovery_out, rec;
  ppw_pkg::ppw_byte_t reg_wdata_in = 8'h00;
  logic [7:0]         ext_val = 8'h00, gpio_out_data_in = 8'h00, periph1_oe_in = 8'h00;
  logic [7:0]         periph2_oe_in = 8'h00, periph3_oe_in = 8'h00, periph1_out_in = 8'h00;
  logic [7:0]         periph2_out_in = 8'h00, periph3_out_in = 8'h00, reg_rdata_out;
  logic [7:0]         pin_level, pin_out, pin_oe_out, edge_irq_out, seen, p, v, n, w;
  logic [3:0]         portc_irq_en_low_out;
  logic [7:0]         pin_sync_out;
  int                 err_total = 0, checks_done = 0;
  always #2.5 core_clk_in = ~core_clk_in;
  ppw_pin_model u_pins (.dev_out_in(pin_out), .dev_oe_in(pin_oe_out), .ext_val_in(ext_val),
    .pin_level_out(pin_level));
  ppw_port_ctl #(.PINS(8)) DUT (.core_clk_in, .rst_n_in, .reg_addr_in, .reg_wr_in,
    .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .pin_in(pin_level), .gpio_out_data_in,
    .periph1_oe_in, .periph1_out_in, .periph2_oe_in, .periph2_out_in, .periph3_oe_in,
    .periph3_out_in, .xtal_enable_in, .stop_mode_in, .xtal_osc_out_in, .pin_out,
    .pin_oe_out, .pin_sync_out, .xtal_in_pin_out, .edge_irq_out, .portc_irq_en_low_out,
    .stop_recovery_out);
  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    cmp(e, reg_rdata_out);
  endtask
  // pick the peripheral chosen by the two set bits
  function automatic logic [7:0] pick(input int s, input logic [7:0] a, b, c);
    return (s == 0) ? a : ((s == 1) ? b : c);
  endfunction
  task automatic results;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    w = 8'($urandom(9));
    repeat (8) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    rd(`PPW_OFF_IRQ_EN_LOW, 8'h00);
    rd(`PPW_OFF_EDGE_POL, 8'h00);
    rd(12'h100, 8'h00);
    wr(`PPW_OFF_PORT_ADDR, `PPW_SUB_WAKE_EN);
    rd(`PPW_OFF_PORT_CTL, 8'h00);
    w = 8'($urandom) & `PPW_IRQ_EN_LOW_MASK;
    wr(`PPW_OFF_IRQ_EN_LOW, w);
    rd(`PPW_OFF_IRQ_EN_LOW, w);
    cmp(w, {4'h0, portc_irq_en_low_out});
    // pins as inputs, then edges and wake sources
    wr(`PPW_OFF_PORT_ADDR, `PPW_SUB_DDR);
    wr(`PPW_OFF_PORT_CTL, 8'hFF);
    wr(`PPW_OFF_PORT_ADDR, `PPW_SUB_WAKE_EN);
    for (int i = 0; i < 8; i++)
    begin
      p = (i == 0) ? 8'hFF : 8'($urandom);
      w = (i == 1) ? 8'h00 : 8'($urandom);
      v = 8'($urandom);
      n = (i == 2) ? ~v : 8'($urandom);
      wr(`PPW_OFF_EDGE_POL, p);
      wr(`PPW_OFF_PORT_CTL, w);
      ext_val <= v;
      stop_mode_in <= (i != 3);
      repeat (7) @(posedge core_clk_in);
      #1;
      cmp(v, pin_sync_out);
      cmp(8'h00, pin_oe_out);
      @(posedge core_clk_in);
      ext_val <= n;
      seen = 8'h00;
      rec = 1'b0;
      repeat (8)
      begin
        @(posedge core_clk_in);
        #1;
        seen |= edge_irq_out;
        rec |= stop_recovery_out;
      end
      cmp((p & ~v & n) | (~p & v & ~n), seen);
      cmp({7'h0, stop_mode_in & (|((v ^ n) & w))}, {7'h0, rec});
    end
    // peripherals take over every pin
    wr(`PPW_OFF_PORT_ADDR, `PPW_SUB_ALT_FUNC);
    wr(`PPW_OFF_PORT_CTL, 8'hFF);
    for (int s = 0; s < 4; s++)
    begin
      wr(`PPW_OFF_PORT_ADDR, `PPW_SUB_AFS_FIRST);
      wr(`PPW_OFF_PORT_CTL, {8{s[0]}});
      wr(`PPW_OFF_PORT_ADDR, `PPW_SUB_AFS_SECOND);
      wr(`PPW_OFF_PORT_CTL, {8{s[1]}});
      {periph1_oe_in, periph2_oe_in, periph3_oe_in} <= 24'($urandom);
      {periph1_out_in, periph2_out_in, periph3_out_in} <= 24'($urandom);
      gpio_out_data_in <= 8'($urandom);
      repeat (3) @(posedge core_clk_in);
      #1;
      cmp(pick(s, periph1_oe_in, periph2_oe_in, periph3_oe_in), pin_oe_out);
      cmp(pick(s, periph1_out_in, periph2_out_in, periph3_out_in), pin_out);
    end
    // crystal takes the first two pins
    @(posedge core_clk_in);
    xtal_enable_in <= 1'b1;
    xtal_osc_out_in <= 1'($urandom);
    ext_val <= 8'hFF;
    repeat (6) @(posedge core_clk_in);
    #1;
    cmp(8'h01, {7'h0, xtal_in_pin_out});
    cmp(8'h02, {6'h0, pin_oe_out[1:0]});
    cmp({7'h0, xtal_osc_out_in}, {7'h0, pin_out[1]});
    // second reset in mid-run with the registers loaded
    wr(`PPW_OFF_IRQ_EN_LOW, `PPW_IRQ_EN_LOW_MASK);
    wr(`PPW_OFF_EDGE_POL, 8'hFF);
    wr(`PPW_OFF_PORT_ADDR, `PPW_SUB_WAKE_EN);
    wr(`PPW_OFF_PORT_CTL, 8'hFF);
    rst_n_in <= 1'b0;
    repeat (8) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    rd(`PPW_OFF_IRQ_EN_LOW, 8'h00);
    rd(`PPW_OFF_EDGE_POL, 8'h00);
    wr(`PPW_OFF_PORT_ADDR, `PPW_SUB_WAKE_EN);
    rd(`PPW_OFF_PORT_CTL, 8'h00);
    cmp(8'hFE, pin_oe_out);
    cmp({gpio_out_data_in[7:2], xtal_osc_out_in, 1'b0}, pin_out);
    results();
  end
  // watchdog against a hang
  initial
  begin
    #50us;
    err_total++;
    results();
  end
endmodule
